// File: pmw_ctrl.sv
`timescale 1ns/10ps
module pmw_ctrl #(
	parameter int unsigned XRST_CYC   = pmw_pkg::PMW_XRST_CYC,
	parameter int unsigned PULSE_CYC  = pmw_pkg::PMW_PULSE_CYC,
	parameter int unsigned SETTLE_CYC = pmw_pkg::PMW_SETTLE_CYC
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire pmw_pkg::pmw_wb_req_t wb_req_i,
	output pmw_pkg::pmw_wb_rsp_t     wb_rsp_o,
	input  wire logic                wake_frame_event_i,
	input  wire logic                energy_event_i,
	output pmw_pkg::pmw_pin_t        wake_event_output_o,
	output logic                     wake_interrupt_o,
	output logic                     transceiver_reset_o,
	output logic [1:0]               power_state_o,
	output logic                     device_alive_o
);
	import pmw_pkg::*;

	pmw_state_t st_reg;
	pmw_state_t st_next;

	logic        req_now;
	logic        rd_now;
	logic        wr_now;
	logic        hit_pwr;
	logic        hit_probe;
	logic        wr_ok;
	logic        reduced;
	logic        xrst_load;
	logic        xrst_done;
	logic        pulse_load;
	logic        pulse_abort;
	logic        pulse_busy;
	logic        settle_load;
	logic        settle_done;
	logic        wake_act;
	logic [31:0] pwr_word;

	// ==========================================================
	// Timers: transceiver reset, wake pulse, settle after wake
	// ==========================================================
	pmw_timer u_xrst_tmr (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.load_i  (xrst_load),
		.abort_i (1'b0),
		.count_i (PMW_TMR_W'(XRST_CYC)),
		.busy_o  (),
		.done_o  (xrst_done)
	);

	pmw_timer u_pulse_tmr (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.load_i  (pulse_load),
		.abort_i (pulse_abort),
		.count_i (PMW_TMR_W'(PULSE_CYC)),
		.busy_o  (pulse_busy),
		.done_o  ()
	);

	pmw_timer u_settle_tmr (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.load_i  (settle_load),
		.abort_i (1'b0),
		.count_i (PMW_TMR_W'(SETTLE_CYC)),
		.busy_o  (),
		.done_o  (settle_done)
	);

	// ==========================================================
	// Read view of the power control register
	// ==========================================================
	always_comb begin
		pwr_word                              = '0;
		pwr_word[PMW_BIT_STATE +: 2]          = st_reg.pwr_state;
		pwr_word[PMW_BIT_XRST]                = st_reg.xrst;
		pwr_word[PMW_BIT_WFE]                 = st_reg.wfe;
		pwr_word[PMW_BIT_EDE]                 = st_reg.ede;
		pwr_word[PMW_BIT_DRIVE]               = st_reg.drive_type;
		pwr_word[PMW_BIT_CAUSE +: 2]          = st_reg.cause;
		pwr_word[PMW_BIT_PULSE]               = st_reg.pulse_sel;
		pwr_word[PMW_BIT_POL]                 = st_reg.pol;
		pwr_word[PMW_BIT_OUT_EN]              = st_reg.out_en;
		pwr_word[PMW_BIT_ALIVE]               = st_reg.alive;
	end

	// ==========================================================
	// Bus decode
	// ==========================================================
	// Every access is answered one cycle after it is seen, mapped or not
	assign req_now   = wb_req_i.cyc && wb_req_i.stb && !st_reg.ack;
	assign rd_now    = req_now && !wb_req_i.we;
	assign wr_now    = req_now && wb_req_i.we;
	assign hit_pwr   = wb_req_i.adr[7:2] == PMW_OFS_PWR[7:2];
	assign hit_probe = wb_req_i.adr[7:2] == PMW_OFS_PROBE[7:2];
	assign reduced   = st_reg.pwr_state != PMW_ST_FULL;
	// Control register writes need a prior read and a settled device
	assign wr_ok     = st_reg.read_seen && st_reg.alive;

	// Timer starts
	assign xrst_load   = wr_now && hit_pwr && wr_ok && wb_req_i.sel[1]
		&& wb_req_i.dat[PMW_BIT_XRST] && !st_reg.xrst;
	assign settle_load = st_reg.waking;
	assign pulse_load  = st_reg.wake_int && !st_reg.int_d && st_reg.pulse_sel;
	// Pulse ends early once the cause or enable goes away
	assign pulse_abort = !st_reg.wake_int || !st_reg.pulse_sel;

	// Pin activity: enable gates the pin only, never the interrupt
	assign wake_act = st_reg.out_en && st_reg.wake_int
		&& (!st_reg.pulse_sel || pulse_busy);

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		st_next = st_reg;
		st_next.ack = req_now;

		// Reads are served in every power state
		if (rd_now) begin
			st_next.read_seen = 1'b1;
			if (hit_pwr) begin
				st_next.rdat = pwr_word;
			end else if (hit_probe) begin
				st_next.rdat = PMW_PROBE_VALUE;
			end else begin
				st_next.rdat = '0;
			end
		end

		// Any probe write wakes; state returns to full power at once
		if (wr_now && hit_probe && reduced) begin
			st_next.pwr_state = PMW_ST_FULL;
			st_next.waking    = 1'b1;
			st_next.read_seen = 1'b0;
		end

		// Settle timer started; alive rises when it runs out
		if (st_reg.waking) begin
			st_next.waking = 1'b0;
		end
		if (settle_done) begin
			st_next.alive = 1'b1;
		end

		// Host writes to the control register
		if (wr_now && hit_pwr && wr_ok) begin
			if (wb_req_i.sel[1]) begin
				if (xrst_load) begin
					st_next.xrst = 1'b1;
				end
				st_next.wfe = wb_req_i.dat[PMW_BIT_WFE];
				st_next.ede = wb_req_i.dat[PMW_BIT_EDE];
				// Reserved code 11 is dropped instead of trusted
				if (wb_req_i.dat[PMW_BIT_STATE +: 2] == PMW_ST_WAKE_DET
					|| wb_req_i.dat[PMW_BIT_STATE +: 2] == PMW_ST_ENERGY) begin
					st_next.pwr_state = wb_req_i.dat[PMW_BIT_STATE +: 2];
					st_next.alive     = 1'b0;
					st_next.read_seen = 1'b0;
				end
			end
			if (wb_req_i.sel[0]) begin
				st_next.drive_type = wb_req_i.dat[PMW_BIT_DRIVE];
				st_next.pulse_sel  = wb_req_i.dat[PMW_BIT_PULSE];
				st_next.pol        = wb_req_i.dat[PMW_BIT_POL];
				st_next.out_en     = wb_req_i.dat[PMW_BIT_OUT_EN];
				// Write one clears; alive implies full power here
				st_next.cause = st_reg.cause & ~wb_req_i.dat[PMW_BIT_CAUSE +: 2];
			end
		end

		// Event capture after the clear so a live source wins
		if (energy_event_i && st_reg.ede) begin
			st_next.cause[0] = 1'b1;
		end
		if (wake_frame_event_i && st_reg.wfe) begin
			st_next.cause[1] = 1'b1;
		end

		// Transceiver released at end of hold
		if (xrst_done) begin
			st_next.xrst = 1'b0;
		end

		// Interrupt follows the latched cause and its enable
		st_next.wake_int = (st_next.cause[1] && st_next.wfe)
			|| (st_next.cause[0] && st_next.ede);
		st_next.int_d    = st_reg.wake_int;
		st_next.pin_act  = wake_act;

		// Pin drive: open-drain ignores polarity
		if (st_reg.drive_type) begin
			st_next.pin.oe  = 1'b1;
			st_next.pin.out = wake_act ? st_reg.pol : !st_reg.pol;
		end else begin
			st_next.pin.oe  = wake_act;
			st_next.pin.out = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= PMW_ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign wb_rsp_o.ack        = st_reg.ack;
	assign wb_rsp_o.dat        = st_reg.rdat;
	assign wake_event_output_o = st_reg.pin;
	assign wake_interrupt_o    = st_reg.wake_int;
	assign transceiver_reset_o = st_reg.xrst;
	assign power_state_o       = st_reg.pwr_state;
	assign device_alive_o      = st_reg.alive;

	// ==========================================================
	// Checks
	// ==========================================================
	// Helper: cycles the transceiver reset has been held
	logic [31:0] xrst_held;
	always_ff @(posedge clk_i) begin
		if (rst_i || !st_reg.xrst) begin
			xrst_held <= '0;
		end else begin
			xrst_held <= xrst_held + 32'h1;
		end
	end

	chk_xrst_min_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(st_reg.xrst) |-> $past(xrst_held) >= XRST_CYC - 1)
		else $error("transceiver reset released too early");

	chk_xrst_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
		st_reg.xrst && !xrst_done |=> st_reg.xrst)
		else $error("transceiver reset dropped before hold ended");

	chk_frame_raises_int: assert property (@(posedge clk_i) disable iff (rst_i)
		wake_frame_event_i && st_reg.wfe |=> wake_interrupt_o && st_reg.cause[1])
		else $error("frame event did not raise interrupt");

	chk_energy_raises_int: assert property (@(posedge clk_i) disable iff (rst_i)
		energy_event_i && st_reg.ede |=> wake_interrupt_o && st_reg.cause[0])
		else $error("energy event did not raise interrupt");

	chk_open_drain_low: assert property (@(posedge clk_i) disable iff (rst_i)
		!st_reg.drive_type |=> !wake_event_output_o.out)
		else $error("open-drain pin driven high");

	chk_cause_clear_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!st_reg.alive && st_reg.cause[1] |=> st_reg.cause[1])
		else $error("cause cleared while not alive");

	chk_pin_off_no_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		st_reg.cause == 2'h0 |=> !st_reg.pin_act)
		else $error("wake pin active without a cause");

	chk_pin_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!st_reg.out_en && st_reg.drive_type |=> wake_event_output_o.out == !$past(st_reg.pol))
		else $error("disabled wake pin shows active level");

	chk_wake_to_full: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_now && hit_probe && reduced |=> power_state_o == PMW_ST_FULL ##1 !device_alive_o)
		else $error("probe write did not return to full power");

	chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_now && hit_pwr |=> wb_rsp_o.ack && wb_rsp_o.dat[31:14] == '0
			&& !wb_rsp_o.dat[11] && !wb_rsp_o.dat[7])
		else $error("reserved bits read nonzero");

	chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack held for more than one cycle");

	// Bus answers, write gating, legal state and reset self-clear
	chk_read_answered: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_now |=> wb_rsp_o.ack)
		else $error("read not answered in the next cycle");

	chk_write_needs_read: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_now && hit_pwr && !st_reg.read_seen |=> st_reg.out_en == $past(st_reg.out_en)
			&& st_reg.wfe == $past(st_reg.wfe))
		else $error("write took effect before a read");

	chk_state_legal: assert property (@(posedge clk_i) disable iff (rst_i)
		power_state_o != 2'h3)
		else $error("reserved power state entered");

	chk_xrst_self_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		xrst_done |=> !transceiver_reset_o)
		else $error("transceiver reset did not self-clear");

	// Pin drive, pulse length and ungated interrupt
	chk_od_active: assert property (@(posedge clk_i) disable iff (rst_i)
		!st_reg.drive_type && wake_act |=> wake_event_output_o.oe && !wake_event_output_o.out)
		else $error("open-drain pin not pulling low when active");

	// Helper: consecutive cycles the wake pin has been pulsed active
	logic [31:0] pulse_held;
	always_ff @(posedge clk_i) begin
		if (rst_i || !wake_act || !st_reg.pulse_sel) begin
			pulse_held <= '0;
		end else begin
			pulse_held <= pulse_held + 32'h1;
		end
	end

	chk_pulse_max: assert property (@(posedge clk_i) disable iff (rst_i)
		wake_act && st_reg.pulse_sel |-> pulse_held < PULSE_CYC)
		else $error("wake pulse longer than its length");

	chk_pulse_min: assert property (@(posedge clk_i) disable iff (rst_i)
		(wake_act && st_reg.pulse_sel && pulse_held < PULSE_CYC - 1)
			##1 (st_reg.wake_int && st_reg.pulse_sel && st_reg.out_en) |-> wake_act)
		else $error("wake pulse ended early");

	chk_enable_drop_pin: assert property (@(posedge clk_i) disable iff (rst_i)
		!st_reg.wfe && !st_reg.ede |=> !st_reg.pin_act)
		else $error("wake pin active with both enables clear");

	chk_pp_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
		st_reg.drive_type && wake_act |=> wake_event_output_o.oe
			&& wake_event_output_o.out == $past(st_reg.pol))
		else $error("push-pull pin shows wrong active level");

	chk_int_no_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_reg.cause[1] && st_reg.wfe) || (st_reg.cause[0] && st_reg.ede)
			|-> wake_interrupt_o)
		else $error("interrupt missing for an enabled cause");

	// Alive only once settled in full power
	chk_reduced_not_alive: assert property (@(posedge clk_i) disable iff (rst_i)
		power_state_o != PMW_ST_FULL |-> !device_alive_o)
		else $error("alive flag set in a reduced state");

	chk_alive_after_settle: assert property (@(posedge clk_i) disable iff (rst_i)
		settle_done |=> device_alive_o)
		else $error("alive flag not set after settling");

endmodule : pmw_ctrl

// File: pmw_ctrl_bench.sv
`timescale 1ns/10ps
module pmw_ctrl_bench;
	import pmw_pkg::*;
	typedef struct packed {
		logic [31:0] w;
		logic [31:0] r;
	} pmw_row_t;
	localparam int XRST = 20;
	localparam int PULSE = 30;
	logic         clk_i;
	logic         rst_i;
	logic         frame_ev;
	logic         energy_ev;
	pmw_wb_req_t  req;
	pmw_wb_rsp_t  rsp;
	pmw_pin_t     pin;
	logic         wake_int;
	logic         xrst;
	logic [1:0]   pstate;
	logic         alive;
	logic [2:0]   obs;
	int           fails;
	int           n_compared;
	int           cycles;
	int           xrst_cnt;
	logic [31:0]  c;
	// Reserved bits written high must read back low
	pmw_row_t     rows [3] = '{'{32'hFFFF_CBCE, 32'h0000_034F},
		'{32'h0000_0248, 32'h0000_0249}, '{32'h0000_0000, 32'h0000_0001}};

	assign obs = {wake_int, pin};

	pmw_host_model i_host (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));
	pmw_ctrl #(.XRST_CYC(XRST), .PULSE_CYC(PULSE), .SETTLE_CYC(5)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
		.wake_frame_event_i(frame_ev), .energy_event_i(energy_ev),
		.wake_event_output_o(pin), .wake_interrupt_o(wake_int),
		.transceiver_reset_o(xrst), .power_state_o(pstate), .device_alive_o(alive));

	// ==========================================================
	// Clock, timeout and reset-length counter
	// ==========================================================
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (xrst === 1'b1) xrst_cnt++;
		if (cycles == 3000) begin
			fails++;
			test_done();
		end
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_out
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		i_host.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		i_host.xfer(1'b0, a, 32'h0, q);
		chk_reg(q, exp);
	endtask : rdc
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : settle
	task automatic evt(input logic fr);
		@(posedge clk_i);
		if (fr) frame_ev <= 1'b1;
		else energy_ev <= 1'b1;
		@(posedge clk_i);
		frame_ev <= 1'b0;
		energy_ev <= 1'b0;
		settle(3);
	endtask : evt
	task automatic wait_alive();
		int n;
		n = 0;
		while (alive !== 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		chk_reg({31'h0, alive}, 32'h1);
	endtask : wait_alive
	function automatic logic [31:0] cfg(input int wf, ed, dr, pu, po, oe);
		logic [31:0] v;
		v = '0;
		{v[PMW_BIT_WFE], v[PMW_BIT_EDE], v[PMW_BIT_DRIVE]} = {wf[0], ed[0], dr[0]};
		{v[PMW_BIT_PULSE], v[PMW_BIT_POL], v[PMW_BIT_OUT_EN]} = {pu[0], po[0], oe[0]};
		return v;
	endfunction : cfg
	task automatic test_done();
		if (fails == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		{rst_i, frame_ev, energy_ev, fails, n_compared, cycles, xrst_cnt} = '1;
		{frame_ev, energy_ev, fails, n_compared, cycles, xrst_cnt} = '0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_alive();
		wr(PMW_OFS_PWR, 32'h2);
		rdc(PMW_OFS_PWR, 32'h1);
		foreach (rows[i]) begin
			wr(PMW_OFS_PWR, rows[i].w);
			rdc(PMW_OFS_PWR, rows[i].r);
		end
		rdc(PMW_OFS_PROBE, PMW_PROBE_VALUE);
		wr(8'h88, 32'hFFFF_FFFF);
		rdc(8'h88, 32'h0);
		rdc(PMW_OFS_PWR, 32'h1);
		// Transceiver reset: a clearing write mid-way must not shorten it
		xrst_cnt = 0;
		wr(PMW_OFS_PWR, 32'h400);
		rdc(PMW_OFS_PWR, 32'h401);
		wr(PMW_OFS_PWR, 32'h0);
		rdc(PMW_OFS_PWR, 32'h401);
		settle(XRST + 5);
		chk_reg(xrst_cnt, XRST);
		rdc(PMW_OFS_PWR, 32'h1);
		// Level mode, push-pull, active high; both causes stack up
		c = cfg(1, 1, 1, 0, 1, 1);
		wr(PMW_OFS_PWR, c);
		evt(1'b0);
		chk_out(obs, 3'b111);
		rdc(PMW_OFS_PWR, c | 32'h11);
		evt(1'b1);
		rdc(PMW_OFS_PWR, c | 32'h31);
		// Sources are already low before the cause is cleared
		wr(PMW_OFS_PWR, c | 32'h30);
		settle(3);
		chk_out(obs, 3'b001);
		rdc(PMW_OFS_PWR, c | 32'h1);
		// Active low push-pull, then dropping the enable
		c = cfg(1, 0, 1, 0, 0, 1);
		wr(PMW_OFS_PWR, c);
		evt(1'b1);
		chk_out(obs, 3'b101);
		wr(PMW_OFS_PWR, cfg(0, 0, 1, 0, 0, 1));
		settle(3);
		chk_out(obs, 3'b011);
		wr(PMW_OFS_PWR, cfg(0, 0, 1, 0, 0, 1) | 32'h20);
		// Open drain with the pin gated off, then on
		c = cfg(1, 0, 0, 0, 1, 0);
		wr(PMW_OFS_PWR, c);
		evt(1'b1);
		chk_out(obs, 3'b100);
		wr(PMW_OFS_PWR, c | 32'h2);
		settle(3);
		chk_out(obs, 3'b101);
		wr(PMW_OFS_PWR, c | 32'h22);
		settle(3);
		chk_out(obs, 3'b000);
		// Pulse mode ends on its own while the interrupt stays
		c = cfg(0, 1, 1, 1, 1, 1);
		wr(PMW_OFS_PWR, c);
		evt(1'b0);
		chk_out(obs, 3'b111);
		settle(PULSE + 5);
		chk_out(obs, 3'b101);
		wr(PMW_OFS_PWR, 32'h10);
		// Reduced states: only this register is read, only the probe written
		for (int s = 1; s < 3; s++) begin
			wr(PMW_OFS_PWR, 32'(s) << 12);
			settle(1);
			chk_reg({29'h0, pstate, alive}, 32'(s) << 1);
			rdc(PMW_OFS_PWR, 32'(s) << 12);
			wr(PMW_OFS_PROBE, 32'h0);
			settle(1);
			chk_reg({30'h0, pstate}, 32'h0);
			wait_alive();
			rdc(PMW_OFS_PWR, 32'h1);
		end
		// Mid-run reset: every field back to zero, settle wait starts again
		wr(PMW_OFS_PWR, cfg(1, 1, 1, 0, 1, 1));
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		settle(1);
		chk_out(obs, 3'b000);
		chk_reg({29'h0, pstate, alive}, 32'h0);
		wait_alive();
		rdc(PMW_OFS_PWR, 32'h1);
		test_done();
	end
endmodule : pmw_ctrl_bench

// File: pmw_host_model.sv
`timescale 1ns/10ps
module pmw_host_model (
	input  wire logic                 clk_i,
	output pmw_pkg::pmw_wb_req_t      req_o,
	input  wire pmw_pkg::pmw_wb_rsp_t rsp_i
);
	import pmw_pkg::*;

	// ==========================================================
	// Classic single-cycle bus master
	// ==========================================================
	// Idle from time zero so nothing is requested during reset
	initial begin
		req_o = '0;
	end

	// Request held until ack is sampled; only the bench timeout ends a dead wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		if (w && a == PMW_OFS_PWR && d[13:12] == 2'h3) begin
			d[13:12] = 2'h0;
		end
		@(posedge clk_i);
		req_o <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
		do begin
			@(posedge clk_i);
		end while (rsp_i.ack !== 1'b1);
		q = rsp_i.dat;
		// Released address and data show the inverse, so stale values never pass as live
		req_o <= '{cyc: 1'b0, stb: 1'b0, we: 1'b0, adr: ~a, sel: 4'h0, dat: ~d};
	endtask : xfer
endmodule : pmw_host_model

// File: pmw_pkg.sv
package pmw_pkg;

	// ==========================================================
	// Register map and fields
	// ==========================================================
	localparam logic [7:0]  PMW_OFS_PWR      = 8'h84;
	localparam logic [7:0]  PMW_OFS_PROBE    = 8'h64;
	localparam logic [31:0] PMW_PROBE_VALUE  = 32'h1357_9BDF; // Arbitrary pattern
	localparam int          PMW_BIT_STATE    = 12;
	localparam int          PMW_BIT_XRST     = 10;
	localparam int          PMW_BIT_WFE      = 9;
	localparam int          PMW_BIT_EDE      = 8;
	localparam int          PMW_BIT_DRIVE    = 6;
	localparam int          PMW_BIT_CAUSE    = 4;
	localparam int          PMW_BIT_PULSE    = 3;
	localparam int          PMW_BIT_POL      = 2;
	localparam int          PMW_BIT_OUT_EN   = 1;
	localparam int          PMW_BIT_ALIVE    = 0;
	localparam logic [1:0]  PMW_ST_FULL      = 2'h0;
	localparam logic [1:0]  PMW_ST_WAKE_DET  = 2'h1;
	localparam logic [1:0]  PMW_ST_ENERGY    = 2'h2;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int PMW_CLK_MHZ     = 200;
	localparam int PMW_XRST_US     = 100;
	localparam int PMW_PULSE_MS    = 50;
	localparam int PMW_SETTLE_US   = 10;
	localparam int PMW_XRST_CYC    = PMW_XRST_US * PMW_CLK_MHZ;
	localparam int PMW_PULSE_CYC   = PMW_PULSE_MS * 1000 * PMW_CLK_MHZ;
	localparam int PMW_SETTLE_CYC  = PMW_SETTLE_US * PMW_CLK_MHZ;
	localparam int PMW_TMR_W       = 24;

	// ==========================================================
	// Carriers and state
	// ==========================================================
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pmw_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pmw_wb_rsp_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pmw_pin_t;

	typedef struct packed {
		logic                 busy;
		logic [PMW_TMR_W-1:0] cnt;
	} pmw_tmr_state_t;

	typedef struct packed {
		logic [1:0]  pwr_state;
		logic        xrst;
		logic        wfe;
		logic        ede;
		logic        drive_type;
		logic [1:0]  cause;
		logic        pulse_sel;
		logic        pol;
		logic        out_en;
		logic        alive;
		logic        waking;
		logic        read_seen;
		logic        wake_int;
		logic        int_d;
		logic        pin_act;
		pmw_pin_t    pin;
		logic        ack;
		logic [31:0] rdat;
	} pmw_state_t;

	localparam pmw_tmr_state_t PMW_TMR_RST = '{default: '0};
	localparam pmw_state_t     PMW_ST_RST  = '{waking: 1'b1, default: '0};

endpackage : pmw_pkg

// File: pmw_timer.sv
`timescale 1ns/10ps
module pmw_timer (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         load_i,
	input  wire logic                         abort_i,
	input  wire logic [pmw_pkg::PMW_TMR_W-1:0] count_i,
	output logic                              busy_o,
	output logic                              done_o
);
	import pmw_pkg::*;

	pmw_tmr_state_t st_reg;
	pmw_tmr_state_t st_next;

	// ==========================================================
	// Down counter, busy for exactly count_i cycles
	// ==========================================================
	always_comb begin
		st_next = st_reg;
		if (load_i) begin
			st_next.busy = 1'b1;
			st_next.cnt  = count_i - PMW_TMR_W'(1);
		end else if (abort_i || (st_reg.busy && st_reg.cnt == '0)) begin
			st_next.busy = 1'b0;
		end else if (st_reg.busy) begin
			st_next.cnt = st_reg.cnt - PMW_TMR_W'(1);
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= PMW_TMR_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Done on the last busy cycle, masked by a restart or abort
	assign busy_o = st_reg.busy;
	assign done_o = st_reg.busy && st_reg.cnt == '0 && !load_i && !abort_i;

endmodule : pmw_timer
